// ===== design/engine_mon_pkg.sv
// package: constants, codes, states and structs for the print engine fault monitor
package engine_mon_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_OPEN_HEAT = 8'h3c;
  localparam logic [7:0] CODE_LOW_HEAT = 8'h3e;
  localparam logic [7:0] CODE_OVER_HEAT = 8'h44;
  localparam logic [7:0] CODE_POLYGON = 8'h5f;
  localparam logic [7:0] CODE_BEAM = 8'h60;
  localparam logic [9:0] TEMP_OPEN_LIMIT = 10'h044;
  localparam logic [9:0] TEMP_STANDBY_LIMIT = 10'h064;
  localparam logic [9:0] TEMP_PRINT_LIMIT = 10'h01e;
  localparam logic [9:0] TEMP_OVER_LIMIT = 10'h0dc;
  localparam int unsigned FEED_JAM_MS = 1000;
  localparam int unsigned OPEN_HEAT_MS = 25000;
  localparam int unsigned STANDBY_LOW_MS = 20000;
  localparam int unsigned PRINT_LOW_MS = 5000;
  localparam int unsigned OVER_HEAT_MS = 3000;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam logic [7:0] PWM_PERIOD = 8'hff;
  localparam logic [25:0] BLINK_HALF = 26'h3b9aca0;
  localparam logic [9:0] TEMP_BAND = 10'h00a;

  typedef enum logic [1:0] {SCAN_IDLE = 2'b00, SCAN_START = 2'b01, SCAN_READY = 2'b11, SCAN_FAULT = 2'b10} scan_e;
  typedef enum logic [1:0] {FUSE_OFF = 2'b00, FUSE_WARM = 2'b01, FUSE_STANDBY = 2'b11, FUSE_PRINT = 2'b10} fuse_e;

  typedef struct packed {
    logic feed;
    logic exit_path;
    logic tray_empty;
    logic manual_tray_sensor;
  } paper_sense_s;

  typedef struct packed {
    logic [7:0] charge;
    logic [7:0] develop;
    logic [7:0] transfer;
  } hv_duty_s;

  typedef struct packed {
    logic red;
    logic all_blink;
    logic feed_jam_fault;
    logic exit_jam_fault;
    logic normal_exit;
  } indicator_s;
endpackage : engine_mon_pkg

// ===== design/print_engine_fault_monitor.sv
// print engine supervision: scan unit start-up, paper path, high-voltage pwm, fuser faults
`timescale 1ns/1ps
module print_engine_fault_monitor
  import engine_mon_pkg::*;
#(
  parameter logic [31:0] FEED_JAM_CYC = 32'(FEED_JAM_MS * CYC_PER_MS),
  // the two long fuser windows need 33 bits at this clock rate
  parameter logic [32:0] OPEN_HEAT_CYC = 33'(64'(OPEN_HEAT_MS) * 64'(CYC_PER_MS)),
  parameter logic [32:0] STANDBY_LOW_CYC = 33'(64'(STANDBY_LOW_MS) * 64'(CYC_PER_MS)),
  parameter logic [31:0] PRINT_LOW_CYC = 32'(PRINT_LOW_MS * CYC_PER_MS),
  parameter logic [31:0] OVER_HEAT_CYC = 32'(OVER_HEAT_MS * CYC_PER_MS),
  parameter logic [25:0] BLINK_HALF_CYC = BLINK_HALF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // system control
  input wire logic print_req_in,
  input wire logic sleep_in,
  input wire logic fault_clear_in,
  input wire logic [31:0] scan_timeout_in,
  input wire logic [31:0] image_delay_in,
  input wire logic [31:0] exit_on_max_in,
  input wire logic [31:0] exit_off_max_in,
  // scan unit
  input wire logic beam_detect_in,
  input wire logic polygon_steady_in,
  input wire logic line_data_valid_in,
  output logic laser_on_out,
  output logic polygon_enable_out,
  output logic scan_ready_out,
  output logic line_send_out,
  // paper path
  input wire engine_mon_pkg::paper_sense_s sense_in,
  input wire logic feed_start_in,
  input wire logic manual_tray_sel_in,
  output logic pick_enable_out,
  output logic image_start_out,
  output logic fan_on_out,
  // high voltage
  input wire engine_mon_pkg::hv_duty_s duty_in,
  input wire logic [9:0] transfer_fb_in,
  input wire logic [9:0] transfer_target_in,
  output logic charge_pwm_out,
  output logic develop_pwm_out,
  output logic transfer_pwm_out,
  // fuser
  input wire engine_mon_pkg::fuse_e fuse_mode_in,
  input wire logic page_done_in,
  input wire logic [9:0] fuser_temp_in,
  input wire logic [9:0] fuser_target_in,
  output logic heater_on_out,
  output logic fuse_range_err_out,
  // diagnostics
  output logic [7:0] diagnostic_code_out,
  output engine_mon_pkg::indicator_s ind_out
);
  import engine_mon_pkg::*;

  function automatic logic [31:0] bump(input logic [31:0] c);
    bump = (c == 32'hffffffff) ? c : c + 32'h1;
  endfunction : bump

  scan_e scan_q, scan_d;
  logic [31:0] scan_cnt_q, scan_cnt_d, feed_cnt_q, feed_cnt_d, img_cnt_q, img_cnt_d;
  logic [31:0] exit_cnt_q, exit_cnt_d, hot_cnt_q, hot_cnt_d;
  logic [32:0] low_cnt_q, low_cnt_d;
  logic feed_wait_q, feed_wait_d, img_wait_q, img_wait_d, exit_prev_q, exit_prev_d;
  logic line_q, line_d, beam_seen_q, beam_seen_d, beam_prev_q, beam_prev_d;
  logic [1:0] pages_q, pages_d;
  logic [7:0] pwm_cnt_q, pwm_cnt_d, xfer_q, xfer_d, code_q, code_d;
  logic [25:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d, feed_jam_q, feed_jam_d, exit_jam_q, exit_jam_d, norm_q, norm_d;
  logic heat_q, heat_d, range_q, range_d, img_start_q, img_start_d, pick_q, pick_d, fan_q, fan_d;
  logic ch_q, ch_d, dv_q, dv_d, tr_q, tr_d;
  logic ready_q, ready_d, red_q, red_d, all_q, all_d;
  logic beam_rise, temp_low;
  logic [32:0] low_limit;

  always_comb begin
    beam_rise = beam_detect_in & ~beam_prev_q;
    scan_d = scan_q;
    scan_cnt_d = scan_cnt_q;
    beam_seen_d = beam_seen_q | beam_rise;
    beam_prev_d = beam_detect_in;
    code_d = code_q;
    line_d = 1'b0;
    unique case (scan_q)
      SCAN_IDLE: begin
        scan_cnt_d = '0;
        beam_seen_d = 1'b0;
        if (print_req_in) begin
          scan_d = SCAN_START;
        end
      end
      SCAN_START: begin
        scan_cnt_d = bump(scan_cnt_q);
        if ((beam_seen_q || beam_rise) && polygon_steady_in) begin
          scan_d = SCAN_READY;
        end else if (scan_cnt_q >= scan_timeout_in) begin
          scan_d = SCAN_FAULT;
          // polygon fault code, or beam code if the polygon is steady; an earlier latched code is kept
          if (code_q == CODE_NONE && !polygon_steady_in) begin
            code_d = CODE_POLYGON;
          end else if (code_q == CODE_NONE) begin
            code_d = CODE_BEAM;
          end
        end
      end
      SCAN_READY: begin
        line_d = beam_rise ? line_data_valid_in : (line_q & line_data_valid_in);
        if (!print_req_in) begin
          scan_d = SCAN_IDLE;
        end
      end
      SCAN_FAULT: begin
        if (fault_clear_in) begin
          scan_d = SCAN_IDLE;
        end
      end
    endcase
    // fuser faults, first one latched wins the code
    temp_low = 1'b0;
    low_limit = STANDBY_LOW_CYC;
    unique case (fuse_mode_in)
      FUSE_WARM: begin
        temp_low = fuser_temp_in < TEMP_OPEN_LIMIT;
        low_limit = OPEN_HEAT_CYC;
      end
      FUSE_STANDBY: begin
        temp_low = fuser_temp_in < TEMP_STANDBY_LIMIT;
      end
      FUSE_PRINT: begin
        temp_low = (pages_q >= 2'd2) && (fuser_temp_in < TEMP_PRINT_LIMIT);
        low_limit = {1'b0, PRINT_LOW_CYC};
      end
      FUSE_OFF: begin
        temp_low = 1'b0;
      end
    endcase
    low_cnt_d = temp_low ? ((&low_cnt_q) ? low_cnt_q : low_cnt_q + 33'h1) : '0;
    hot_cnt_d = (fuser_temp_in > TEMP_OVER_LIMIT) ? bump(hot_cnt_q) : '0;
    pages_d = (fuse_mode_in != FUSE_PRINT) ? 2'd0 : ((page_done_in && pages_q != 2'd3) ? pages_q + 2'd1 : pages_q);
    if (code_q == CODE_NONE) begin
      if (hot_cnt_q > OVER_HEAT_CYC) begin
        code_d = CODE_OVER_HEAT;
      end else if (low_cnt_q > low_limit && fuse_mode_in == FUSE_WARM) begin
        code_d = CODE_OPEN_HEAT;
      end else if (low_cnt_q > low_limit) begin
        code_d = CODE_LOW_HEAT;
      end
    end
    if (fault_clear_in && code_d == code_q) begin
      code_d = CODE_NONE;
    end
  end

  always_comb begin
    feed_wait_d = feed_wait_q;
    feed_cnt_d = feed_wait_q ? bump(feed_cnt_q) : '0;
    feed_jam_d = feed_jam_q & ~fault_clear_in;
    if (feed_start_in && pick_q) begin
      feed_wait_d = 1'b1;
      feed_cnt_d = '0;
    end else if (feed_wait_q && sense_in.feed) begin
      feed_wait_d = 1'b0;
    end else if (feed_wait_q && feed_cnt_q >= FEED_JAM_CYC) begin
      feed_wait_d = 1'b0;
      feed_jam_d = 1'b1;
    end
    img_start_d = 1'b0;
    img_wait_d = img_wait_q;
    img_cnt_d = img_wait_q ? bump(img_cnt_q) : '0;
    if (feed_wait_q && sense_in.feed) begin
      img_wait_d = 1'b1;
      img_cnt_d = '0;
    end else if (img_wait_q && img_cnt_q >= image_delay_in) begin
      img_wait_d = 1'b0;
      img_start_d = 1'b1;
    end
    exit_prev_d = sense_in.exit_path;
    exit_cnt_d = (sense_in.exit_path != exit_prev_q) ? '0 : bump(exit_cnt_q);
    exit_jam_d = exit_jam_q & ~fault_clear_in;
    norm_d = 1'b0;
    if (sense_in.exit_path && exit_cnt_q >= exit_on_max_in) begin
      exit_jam_d = 1'b1;
    end else if (!sense_in.exit_path && exit_prev_q) begin
      norm_d = ~exit_jam_q;
    end
    if (!sense_in.exit_path && img_wait_q && exit_cnt_q >= exit_off_max_in && exit_off_max_in != '0) begin
      exit_jam_d = 1'b1;
    end
    pick_d = manual_tray_sel_in ? sense_in.manual_tray_sensor : ~sense_in.tray_empty;
    fan_d = ~sleep_in;
    blink_cnt_d = (blink_cnt_q == BLINK_HALF_CYC) ? '0 : blink_cnt_q + 26'h1;
    blink_d = (blink_cnt_q == BLINK_HALF_CYC) ? ~blink_q : blink_q;
  end

  always_comb begin
    pwm_cnt_d = (pwm_cnt_q == PWM_PERIOD) ? 8'h00 : pwm_cnt_q + 8'h01;
    ch_d = pwm_cnt_q < duty_in.charge;
    dv_d = pwm_cnt_q < duty_in.develop;
    tr_d = pwm_cnt_q < xfer_q;
    // transfer feedback trim, once per pwm period
    xfer_d = xfer_q;
    if (!img_wait_q && !sense_in.exit_path) begin
      xfer_d = duty_in.transfer;
    end else if (pwm_cnt_q == PWM_PERIOD) begin
      if (transfer_fb_in < transfer_target_in && xfer_q != 8'hff) begin
        xfer_d = xfer_q + 8'h01;
      end else if (transfer_fb_in > transfer_target_in && xfer_q != 8'h00) begin
        xfer_d = xfer_q - 8'h01;
      end
    end
    heat_d = (fuse_mode_in != FUSE_OFF) && (code_q == CODE_NONE) && (fuser_temp_in < fuser_target_in);
    range_d = range_q & ~fault_clear_in;
    if (fuse_mode_in == FUSE_PRINT && ({1'b0, fuser_temp_in} + {1'b0, TEMP_BAND} < {1'b0, fuser_target_in} ||
        {1'b0, fuser_temp_in} > {1'b0, fuser_target_in} + {1'b0, TEMP_BAND})) begin
      range_d = 1'b1;
    end
    // indicators registered from next values so they leave flops without an extra cycle
    ready_d = scan_d == SCAN_READY;
    // red lit on a jam, flashing while the tray is empty
    red_d = feed_jam_d | exit_jam_d | (sense_in.tray_empty & blink_d);
    // all indicators blink on any latched code
    all_d = (code_d != CODE_NONE) & blink_d;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scan_q <= SCAN_IDLE;
      {scan_cnt_q, feed_cnt_q, img_cnt_q, exit_cnt_q, low_cnt_q, hot_cnt_q} <= '0;
      {feed_wait_q, img_wait_q, exit_prev_q, line_q, beam_seen_q, beam_prev_q} <= '0;
      {pages_q, pwm_cnt_q, xfer_q, code_q, blink_cnt_q, blink_q} <= '0;
      {feed_jam_q, exit_jam_q, norm_q, heat_q, range_q, img_start_q, pick_q, fan_q} <= '0;
      {ch_q, dv_q, tr_q} <= '0;
      {ready_q, red_q, all_q} <= '0;
    end else begin
      scan_q <= scan_d;
      {scan_cnt_q, feed_cnt_q, img_cnt_q, exit_cnt_q, low_cnt_q, hot_cnt_q} <=
        {scan_cnt_d, feed_cnt_d, img_cnt_d, exit_cnt_d, low_cnt_d, hot_cnt_d};
      {feed_wait_q, img_wait_q, exit_prev_q, line_q, beam_seen_q, beam_prev_q} <=
        {feed_wait_d, img_wait_d, exit_prev_d, line_d, beam_seen_d, beam_prev_d};
      {pages_q, pwm_cnt_q, xfer_q, code_q, blink_cnt_q, blink_q} <=
        {pages_d, pwm_cnt_d, xfer_d, code_d, blink_cnt_d, blink_d};
      {feed_jam_q, exit_jam_q, norm_q, heat_q, range_q, img_start_q, pick_q, fan_q} <=
        {feed_jam_d, exit_jam_d, norm_d, heat_d, range_d, img_start_d, pick_d, fan_d};
      {ch_q, dv_q, tr_q} <= {ch_d, dv_d, tr_d};
      {ready_q, red_q, all_q} <= {ready_d, red_d, all_d};
    end
  end

  // gray coding puts start and ready, and only those, on bit 0
  assign laser_on_out = scan_q[0];
  assign polygon_enable_out = scan_q[0];
  assign scan_ready_out = ready_q;
  assign line_send_out = line_q;
  assign pick_enable_out = pick_q;
  assign image_start_out = img_start_q;
  assign fan_on_out = fan_q;
  assign charge_pwm_out = ch_q;
  assign develop_pwm_out = dv_q;
  assign transfer_pwm_out = tr_q;
  assign heater_on_out = heat_q;
  assign fuse_range_err_out = range_q;
  assign diagnostic_code_out = code_q;
  assign ind_out.red = red_q;
  assign ind_out.all_blink = all_q;
  assign ind_out.feed_jam_fault = feed_jam_q;
  assign ind_out.exit_jam_fault = exit_jam_q;
  assign ind_out.normal_exit = norm_q;
endmodule : print_engine_fault_monitor

// ===== testbench/engine_mon_assertions.sv
// concurrent checks on the fault monitor ports
`timescale 1ns/1ps
module engine_mon_chk
  import engine_mon_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sleep_in,
  input wire logic fault_clear_in,
  input wire logic beam_detect_in,
  input wire logic polygon_steady_in,
  input wire logic manual_tray_sel_in,
  input wire engine_mon_pkg::paper_sense_s sense_in,
  input wire engine_mon_pkg::hv_duty_s duty_in,
  input wire logic [9:0] fuser_temp_in,
  input wire logic laser_on_out,
  input wire logic scan_ready_out,
  input wire logic line_send_out,
  input wire logic pick_enable_out,
  input wire logic fan_on_out,
  input wire logic charge_pwm_out,
  input wire logic [7:0] diagnostic_code_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_fan_sleep;
    sleep_in |=> !fan_on_out;
  endproperty
  a_fan_sleep: assert property (p_fan_sleep) else $error("fan running in sleep");
  property p_send_beam;
    $rose(line_send_out) |-> $past(beam_detect_in) && !$past(beam_detect_in, 2);
  endproperty
  a_send_beam: assert property (p_send_beam) else $error("line opened without beam");
  property p_ready_cause;
    $rose(scan_ready_out) |-> $past(polygon_steady_in) && laser_on_out;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without steady");
  property p_code_poly;
    $changed(diagnostic_code_out) && diagnostic_code_out == CODE_POLYGON |-> !$past(polygon_steady_in);
  endproperty
  a_code_poly: assert property (p_code_poly) else $error("polygon code while steady");
  property p_code_beam;
    $changed(diagnostic_code_out) && diagnostic_code_out == CODE_BEAM |-> $past(polygon_steady_in);
  endproperty
  a_code_beam: assert property (p_code_beam) else $error("beam code while unsteady");
  property p_code_held;
    diagnostic_code_out != CODE_NONE && !fault_clear_in |=> $stable(diagnostic_code_out);
  endproperty
  a_code_held: assert property (p_code_held) else $error("code changed uncleared");
  property p_manual;
    manual_tray_sel_in && !sense_in.manual_tray_sensor |=> !pick_enable_out;
  endproperty
  a_manual: assert property (p_manual) else $error("manual pick with no paper");
  // duty zero must keep the pwm low once the pipe has flushed
  property p_zero_duty;
    duty_in.charge == 8'h00 [*3] |=> !charge_pwm_out;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("charge pwm high at zero duty");
  property p_over_cause;
    $changed(diagnostic_code_out) && diagnostic_code_out == CODE_OVER_HEAT |-> $past(fuser_temp_in, 2) > TEMP_OVER_LIMIT;
  endproperty
  a_over_cause: assert property (p_over_cause) else $error("over-heat code when cool");
  c_ready: cover property ($rose(scan_ready_out));
  c_over: cover property (diagnostic_code_out == CODE_OVER_HEAT);
  c_pick: cover property ($fell(pick_enable_out));
endmodule : engine_mon_chk

// ===== testbench/scan_unit_model.sv
// laser unit model: polygon spin-up and beam-detect pulses
`timescale 1ns/1ps
module scan_unit_model #(
  parameter int SPIN = 20,
  parameter int LINE = 32
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic laser_on_in,
  input wire logic polygon_enable_in,
  input wire logic [1:0] mode_in,
  output logic beam_detect_out,
  output logic polygon_steady_out
);
  int spin_q;
  int line_q;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in || !polygon_enable_in) begin
      spin_q <= 0;
      line_q <= 0;
      beam_detect_out <= 1'b0;
      polygon_steady_out <= 1'b0;
    end else begin
      spin_q <= spin_q + (spin_q < SPIN);
      line_q <= (line_q + 1) % LINE;
      // mode 1: motor never reaches speed
      polygon_steady_out <= spin_q >= SPIN && mode_in != 2'd1;
      // pulse per facet; mode 2 beam never hits sensor
      beam_detect_out <= laser_on_in && mode_in != 2'd2 && line_q < 2;
    end
  end
endmodule : scan_unit_model

// ===== testbench/testbench.sv
// self-checking bench for the print engine fault monitor
`timescale 1ns/1ps
module testbench;
  import engine_mon_pkg::*;
  logic clk_in, rstn_in, print_req_in, sleep_in, fault_clear_in, beam_detect_in, polygon_steady_in;
  logic line_data_valid_in, feed_start_in, manual_tray_sel_in, page_done_in;
  logic laser_on_out, polygon_enable_out, scan_ready_out, line_send_out, pick_enable_out;
  logic image_start_out, fan_on_out, charge_pwm_out, develop_pwm_out, transfer_pwm_out;
  logic heater_on_out, fuse_range_err_out;
  logic [31:0] scan_timeout_in, image_delay_in, exit_on_max_in, exit_off_max_in;
  logic [9:0] transfer_fb_in, transfer_target_in, fuser_temp_in, fuser_target_in;
  logic [7:0] diagnostic_code_out;
  logic [1:0] pmode;
  paper_sense_s sense_in;
  hv_duty_s duty_in;
  fuse_e fuse_mode_in;
  indicator_s ind_out;
  int error_cnt = 0, n_compared = 0, seed = 32'h803c, n, m;
  int hi[3];
  int exp_q[$];
  logic [9:0] t_tab[4] = '{10'd300, 10'd50, 10'd20, 10'd90};
  logic [7:0] c_tab[4] = '{CODE_OVER_HEAT, CODE_OPEN_HEAT, CODE_LOW_HEAT, CODE_LOW_HEAT};
  print_engine_fault_monitor #(.FEED_JAM_CYC(32'd100), .OPEN_HEAT_CYC(33'd60), .STANDBY_LOW_CYC(33'd70),
    .PRINT_LOW_CYC(32'd50), .OVER_HEAT_CYC(32'd40), .BLINK_HALF_CYC(26'd7)) i_dut (.clk_in, .rstn_in,
    .print_req_in, .sleep_in,
    .fault_clear_in, .scan_timeout_in, .image_delay_in, .exit_on_max_in, .exit_off_max_in, .beam_detect_in,
    .polygon_steady_in, .line_data_valid_in, .laser_on_out, .polygon_enable_out, .scan_ready_out, .line_send_out,
    .sense_in, .feed_start_in, .manual_tray_sel_in, .pick_enable_out, .image_start_out, .fan_on_out, .duty_in,
    .transfer_fb_in, .transfer_target_in, .charge_pwm_out, .develop_pwm_out, .transfer_pwm_out, .fuse_mode_in,
    .page_done_in, .fuser_temp_in, .fuser_target_in, .heater_on_out, .fuse_range_err_out, .diagnostic_code_out,
    .ind_out);
  scan_unit_model i_scan (.clk_in, .rstn_in, .laser_on_in(laser_on_out), .polygon_enable_in(polygon_enable_out),
    .mode_in(pmode), .beam_detect_out(beam_detect_in), .polygon_steady_out(polygon_steady_in));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic cyc(int k);
    repeat (k) @(negedge clk_in);
  endtask : cyc
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset();
    rstn_in = 1'b0;
    cyc(3);
    rstn_in = 1'b1;
  endtask : do_reset
  task automatic pulse_clear();
    fault_clear_in = 1'b1;
    cyc(1);
    fault_clear_in = 1'b0;
    cyc(2);
  endtask : pulse_clear
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    {print_req_in, sleep_in, fault_clear_in, line_data_valid_in, feed_start_in, manual_tray_sel_in} = '0;
    {page_done_in, pmode, sense_in, duty_in} = '0;
    fuse_mode_in = FUSE_OFF;
    {scan_timeout_in, image_delay_in, exit_on_max_in, exit_off_max_in} = {32'd200, 32'd7, 32'd30, 32'd0};
    {transfer_fb_in, transfer_target_in, fuser_temp_in, fuser_target_in} = {4{10'd150}};
    do_reset();
    chk("code_rst", 0, diagnostic_code_out);
    print_req_in = 1'b1;
    line_data_valid_in = 1'b1;
    for (n = 0; n < 400 && scan_ready_out !== 1'b1; n++) cyc(1);
    chk("ready", 1, scan_ready_out && laser_on_out && polygon_enable_out);
    for (n = 0; n < 100 && beam_detect_in !== 1'b1; n++) cyc(1);
    cyc(2);
    chk("line_send", 1, line_send_out);
    print_req_in = 1'b0;
    cyc(3);
    chk("ready_drop", 0, scan_ready_out);
    for (int i = 1; i < 3; i++) begin
      pmode = 2'(i);
      print_req_in = 1'b1;
      cyc(240);
      chk("scan_code", i == 1 ? CODE_POLYGON : CODE_BEAM, diagnostic_code_out);
      print_req_in = 1'b0;
      pmode = 2'd0;
      pulse_clear();
      chk("scan_clear", 0, diagnostic_code_out);
    end
    $display("scan tests done");
    for (int i = 0; i < 4; i++) begin
      image_delay_in = 32'($unsigned($random(seed)) % 20);
      exp_q.push_back(int'(image_delay_in) + 3);
      feed_start_in = 1'b1;
      cyc(1);
      feed_start_in = 1'b0;
      cyc(5 + $unsigned($random(seed)) % 40);
      sense_in.feed = 1'b1;
      for (n = 1; n < 60 && image_start_out !== 1'b1; n++) cyc(1);
      chk("image_delay", exp_q.pop_front(), n);
      cyc(30);
      sense_in.feed = 1'b0;
      cyc(5);
    end
    chk("no_jam", 0, ind_out.feed_jam_fault);
    feed_start_in = 1'b1;
    cyc(1);
    feed_start_in = 1'b0;
    cyc(115);
    chk("feed_jam", 3, {ind_out.feed_jam_fault, ind_out.red});
    do_reset();
    sense_in.exit_path = 1'b1;
    cyc(10);
    sense_in.exit_path = 1'b0;
    cyc(1);
    chk("exit_norm", 1, ind_out.normal_exit);
    cyc(9);
    chk("exit_ok", 0, ind_out.exit_jam_fault);
    sense_in.exit_path = 1'b1;
    cyc(50);
    chk("exit_jam", 3, {ind_out.exit_jam_fault, ind_out.red});
    sense_in.exit_path = 1'b0;
    do_reset();
    sense_in.tray_empty = 1'b1;
    cyc(2);
    chk("pick_empty", 0, pick_enable_out);
    hi[0] = 0;
    repeat (16) begin
      cyc(1);
      hi[0] += ind_out.red;
    end
    chk("red_flash", 8, hi[0]);
    manual_tray_sel_in = 1'b1;
    cyc(2);
    chk("pick_manual0", 0, pick_enable_out);
    sense_in.manual_tray_sensor = 1'b1;
    cyc(2);
    chk("pick_manual1", 1, pick_enable_out);
    sleep_in = 1'b1;
    cyc(2);
    chk("fan_sleep", 0, fan_on_out);
    sleep_in = 1'b0;
    cyc(2);
    chk("fan_wake", 1, fan_on_out);
    $display("paper path tests done");
    for (int r = 0; r < 3; r++) begin
      duty_in = hv_duty_s'(24'($random(seed)));
      hi = '{0, 0, 0};
      cyc(300);
      repeat (256) begin
        cyc(1);
        hi[0] += charge_pwm_out;
        hi[1] += develop_pwm_out;
        hi[2] += transfer_pwm_out;
      end
      chk("charge_duty", duty_in.charge, hi[0]);
      chk("develop_duty", duty_in.develop, hi[1]);
      chk("transfer_duty", duty_in.transfer, hi[2]);
    end
    // sheet held at the exit sensor keeps transfer active; low feedback raises the duty once a period
    exit_on_max_in = 32'd4000;
    duty_in.transfer = 8'h40;
    transfer_fb_in = 10'd100;
    cyc(3);
    sense_in.exit_path = 1'b1;
    cyc(1024);
    hi[2] = 0;
    repeat (256) begin
      cyc(1);
      hi[2] += transfer_pwm_out;
    end
    chk("xfer_trim", 1, hi[2] == 32'h44 || hi[2] == 32'h45);
    sense_in.exit_path = 1'b0;
    transfer_fb_in = 10'd150;
    exit_on_max_in = 32'd30;
    fuse_mode_in = FUSE_STANDBY;
    fuser_temp_in = 10'd120;
    cyc(3);
    chk("heat_on", 1, heater_on_out);
    fuser_temp_in = 10'd180;
    cyc(3);
    chk("heat_off", 0, heater_on_out);
    for (int i = 0; i < 4; i++) begin
      fuse_mode_in = fuse_e'(i);
      repeat (i == 2 ? 2 : 0) begin
        page_done_in = 1'b1;
        cyc(1);
        page_done_in = 1'b0;
        cyc(1);
      end
      fuser_temp_in = t_tab[i];
      cyc(100);
      chk("fuse_code", c_tab[i], diagnostic_code_out);
      chk("heat_cut", 0, heater_on_out);
      hi[0] = 0;
      repeat (16) begin
        cyc(1);
        hi[0] += ind_out.all_blink;
      end
      chk("blink_flag", 8, hi[0]);
      if (i == 2) chk("range_err", 1, fuse_range_err_out);
      fuser_temp_in = 10'd150;
      fuse_mode_in = FUSE_OFF;
      pulse_clear();
      chk("fuse_clear", 0, diagnostic_code_out);
    end
    $display("pwm and fuser tests done");
    give_verdict();
  end
endmodule : testbench
bind print_engine_fault_monitor engine_mon_chk i_chk (.clk_in, .rstn_in, .sleep_in, .fault_clear_in,
  .beam_detect_in, .polygon_steady_in, .manual_tray_sel_in, .sense_in, .duty_in, .fuser_temp_in, .laser_on_out,
  .scan_ready_out, .line_send_out, .pick_enable_out, .fan_on_out, .charge_pwm_out, .diagnostic_code_out);
